// ==== cmd_decoder_consts.svh ====
`ifndef CMD_DECODER_CONSTS_SVH
`define CMD_DECODER_CONSTS_SVH

// command byte layout
`define CMD_START_BIT      7
`define CMD_DIR_BIT        6
`define CMD_IDX_MSB        5
`define CMD_IDX_LSB        0
`define CMD_RESET          8'h00
`define CMD_DIR_WRITE      1'b0
`define CMD_START_OK       1'b0

// target register index codes
`define IDX_COMMAND        6'h00
`define IDX_STATUS         6'h00
`define IDX_CONV_MODE      6'h01
`define IDX_IFACE_MODE     6'h02
`define IDX_CHECKSUM       6'h03
`define IDX_RESULT         6'h04
`define IDX_GPIO_CFG       6'h06
`define IDX_IDENT          6'h07
`define IDX_GROUP_CHANNEL  2'h1
`define IDX_GROUP_SETUP    3'h4
`define IDX_GROUP_FILTER   3'h5
`define IDX_GROUP_OFFSET   3'h6
`define IDX_GROUP_GAIN     3'h7
`define STATUS_RESET       8'h80

// data phase lengths in bytes
`define LEN_NONE           2'd0
`define LEN_STATUS         2'd1
`define LEN_CONV_MODE      2'd2
`define LEN_IFACE_MODE     2'd2
`define LEN_CHECKSUM       2'd3
`define LEN_RESULT         2'd3
`define LEN_GPIO_CFG       2'd2
`define LEN_IDENT          2'd2
`define LEN_CHANNEL        2'd2
`define LEN_SETUP          2'd2
`define LEN_FILTER         2'd2
`define LEN_OFFSET         2'd3
`define LEN_GAIN           2'd3

`endif

// ==== cmd_decoder_pkg.sv ====
package cmd_decoder_pkg;

    typedef enum logic [3:0] {
        TGT_NONE       = 4'h0,
        TGT_STATUS     = 4'h1,
        TGT_CONV_MODE  = 4'h2,
        TGT_IFACE_MODE = 4'h3,
        TGT_CHECKSUM   = 4'h4,
        TGT_RESULT     = 4'h5,
        TGT_GPIO_CFG   = 4'h6,
        TGT_IDENT      = 4'h7,
        TGT_CHANNEL    = 4'h8,
        TGT_SETUP      = 4'h9,
        TGT_FILTER     = 4'ha,
        TGT_OFFSET     = 4'hb,
        TGT_GAIN       = 4'hc,
        TGT_COMMAND    = 4'hd
    } target_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01
    } phase_t;

endpackage : cmd_decoder_pkg

// ==== command_byte_register_decoder.sv ====
// Behaviour
// - first byte of each transaction is command
// - command selects target register and direction
// - command accepted only when bit 7 zero
// - direction bit 0 write, 1 read
// - low six bits give target register index
// - decode status, modes, checksum, result, gpio, id
// - channel 0-15 and setup 0-7 codes
// - filter, offset and gain 0-7 codes
// - command register index zero, reset zero, write-only
// - read of index zero targets status
`timescale 1ns/1ns
`default_nettype none
`include "cmd_decoder_consts.svh"

module command_byte_register_decoder (
    input  wire logic                     mclk,
    input  wire logic                     rst_n,
    input  wire logic                     byteValid,
    input  wire logic [7:0]               byteData,
    input  wire logic                     frameAbort,
    output logic [7:0]                    commandByte,
    output cmd_decoder_pkg::target_t      targetClass,
    output logic [3:0]                    targetUnit,
    output logic                          readNotWrite,
    output logic                          phaseActive,
    output logic [1:0]                    phaseBytes,
    output logic                          readStrobe,
    output logic                          writeStrobe,
    output logic [23:0]                   writeData,
    output logic                          phaseDone,
    output logic                          commandRejected
);
    import cmd_decoder_pkg::*;

    phase_t      stateQ,   stateD;
    logic [7:0]  cmdQ,     cmdD;
    target_t     classQ,   classD;
    logic [3:0]  unitQ,    unitD;
    logic        rdQ,      rdD;
    logic [1:0]  lenQ,     lenD;
    logic [1:0]  cntQ,     cntD;
    logic [23:0] shiftQ,   shiftD;
    logic        wrStbQ,   wrStbD;
    logic [23:0] wrDataQ,  wrDataD;
    logic        rdStbQ,   rdStbD;
    logic        doneQ,    doneD;
    logic        rejQ,     rejD;

    target_t     decClass;
    logic [3:0]  decUnit;
    logic [1:0]  decLen;
    logic [5:0]  idx;
    logic        isRead;

    assign idx    = byteData[`CMD_IDX_MSB:`CMD_IDX_LSB];
    assign isRead = (byteData[`CMD_DIR_BIT] != `CMD_DIR_WRITE);

    // index decode; groups of eight or sixteen share a class and carry a unit number
    always_comb
    begin
        decClass = TGT_NONE;
        decUnit  = 4'h0;
        decLen   = `LEN_NONE;
        if (idx == `IDX_STATUS && isRead)
        begin
            decClass = TGT_STATUS;
            decLen   = `LEN_STATUS;
        end
        else if (idx == `IDX_COMMAND)
        begin
            // a write here only reloads the command byte, so no data phase follows
            decClass = TGT_COMMAND;
            decLen   = `LEN_NONE;
        end
        else if (idx == `IDX_CONV_MODE)
        begin
            decClass = TGT_CONV_MODE;
            decLen   = `LEN_CONV_MODE;
        end
        else if (idx == `IDX_IFACE_MODE)
        begin
            decClass = TGT_IFACE_MODE;
            decLen   = `LEN_IFACE_MODE;
        end
        else if (idx == `IDX_CHECKSUM)
        begin
            decClass = TGT_CHECKSUM;
            decLen   = `LEN_CHECKSUM;
        end
        else if (idx == `IDX_RESULT)
        begin
            decClass = TGT_RESULT;
            decLen   = `LEN_RESULT;
        end
        else if (idx == `IDX_GPIO_CFG)
        begin
            decClass = TGT_GPIO_CFG;
            decLen   = `LEN_GPIO_CFG;
        end
        else if (idx == `IDX_IDENT)
        begin
            decClass = TGT_IDENT;
            decLen   = `LEN_IDENT;
        end
        else if (idx[5:4] == `IDX_GROUP_CHANNEL)
        begin
            decClass = TGT_CHANNEL;
            decUnit  = idx[3:0];
            decLen   = `LEN_CHANNEL;
        end
        else if (idx[5:3] == `IDX_GROUP_SETUP)
        begin
            decClass = TGT_SETUP;
            decUnit  = {1'b0, idx[2:0]};
            decLen   = `LEN_SETUP;
        end
        else if (idx[5:3] == `IDX_GROUP_FILTER)
        begin
            decClass = TGT_FILTER;
            decUnit  = {1'b0, idx[2:0]};
            decLen   = `LEN_FILTER;
        end
        else if (idx[5:3] == `IDX_GROUP_OFFSET)
        begin
            decClass = TGT_OFFSET;
            decUnit  = {1'b0, idx[2:0]};
            decLen   = `LEN_OFFSET;
        end
        else if (idx[5:3] == `IDX_GROUP_GAIN)
        begin
            decClass = TGT_GAIN;
            decUnit  = {1'b0, idx[2:0]};
            decLen   = `LEN_GAIN;
        end
        else
        begin
            // 000101 and 001xxx: reserved, no strobe will ever fire
            decClass = TGT_NONE;
            decLen   = `LEN_NONE;
        end
    end

    always_comb
    begin
        stateD  = stateQ;
        cmdD    = cmdQ;
        classD  = classQ;
        unitD   = unitQ;
        rdD     = rdQ;
        lenD    = lenQ;
        cntD    = cntQ;
        shiftD  = shiftQ;
        wrStbD  = 1'b0;
        wrDataD = wrDataQ;
        rdStbD  = 1'b0;
        doneD   = 1'b0;
        rejD    = 1'b0;
        case (stateQ)
            ST_IDLE:
            begin
                if (byteValid && !frameAbort)
                begin
                    if (byteData[`CMD_START_BIT] == `CMD_START_OK)
                    begin
                        cmdD   = byteData;
                        classD = decClass;
                        unitD  = decUnit;
                        rdD    = isRead;
                        lenD   = decLen;
                        cntD   = 2'd0;
                        shiftD = 24'h000000;
                        if (decLen != `LEN_NONE)
                        begin
                            stateD = ST_DATA;
                            // read strobe lets the register bank load its value before the first byte
                            rdStbD = isRead;
                        end
                        else
                        begin
                            doneD = 1'b1;
                        end
                    end
                    else
                    begin
                        // host held the start bit high: byte is not a command
                        rejD = 1'b1;
                    end
                end
            end
            ST_DATA:
            begin
                if (frameAbort)
                begin
                    // partial write is dropped; no register changes on a cut frame
                    stateD = ST_IDLE;
                end
                else if (byteValid)
                begin
                    shiftD = {shiftQ[15:0], byteData};
                    cntD   = 2'(cntQ + 2'd1);
                    if (2'(cntQ + 2'd1) == lenQ)
                    begin
                        stateD = ST_IDLE;
                        doneD  = 1'b1;
                        if (!rdQ && classQ != TGT_NONE)
                        begin
                            wrStbD  = 1'b1;
                            wrDataD = {shiftQ[15:0], byteData};
                        end
                    end
                end
            end
            default:
            begin
                stateD = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            stateQ  <= ST_IDLE;
            cmdQ    <= `CMD_RESET;
            classQ  <= TGT_NONE;
            unitQ   <= 4'h0;
            rdQ     <= 1'b0;
            lenQ    <= `LEN_NONE;
            cntQ    <= 2'd0;
            shiftQ  <= 24'h000000;
            wrStbQ  <= 1'b0;
            wrDataQ <= 24'h000000;
            rdStbQ  <= 1'b0;
            doneQ   <= 1'b0;
            rejQ    <= 1'b0;
        end
        else
        begin
            stateQ  <= stateD;
            cmdQ    <= cmdD;
            classQ  <= classD;
            unitQ   <= unitD;
            rdQ     <= rdD;
            lenQ    <= lenD;
            cntQ    <= cntD;
            shiftQ  <= shiftD;
            wrStbQ  <= wrStbD;
            wrDataQ <= wrDataD;
            rdStbQ  <= rdStbD;
            doneQ   <= doneD;
            rejQ    <= rejD;
        end
    end

    assign commandByte     = cmdQ;
    assign targetClass     = classQ;
    assign targetUnit      = unitQ;
    assign readNotWrite    = rdQ;
    assign phaseActive     = (stateQ == ST_DATA);
    assign phaseBytes      = lenQ;
    assign readStrobe      = rdStbQ;
    assign writeStrobe     = wrStbQ;
    assign writeData       = wrDataQ;
    assign phaseDone       = doneQ;
    assign commandRejected = rejQ;

endmodule : command_byte_register_decoder

`default_nettype wire

// ==== command_byte_register_decoder_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module command_byte_register_decoder_checker (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                byteValid,
    input wire logic [7:0]          byteData,
    input wire logic                frameAbort,
    input wire logic [7:0]          commandByte,
    input wire cmd_decoder_pkg::target_t targetClass,
    input wire logic [3:0]          targetUnit,
    input wire logic                readNotWrite,
    input wire logic                phaseActive,
    input wire logic [1:0]          phaseBytes,
    input wire logic                readStrobe,
    input wire logic                writeStrobe,
    input wire logic                phaseDone,
    input wire logic                commandRejected
);
    import cmd_decoder_pkg::*;
    logic take;
    logic idleByte;
    assign idleByte = byteValid && !frameAbort && !phaseActive;
    assign take = idleByte && !byteData[7];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    reject_idle_a: assert property (idleByte && byteData[7] |=> commandRejected && !phaseActive && !readStrobe)
        else $error("bad rejection");
    cmd_capture_a: assert property (take |=> commandByte == $past(byteData) && !commandRejected)
        else $error("command not captured");
    dir_bit_a: assert property (take |=> readNotWrite == $past(byteData[6]))
        else $error("direction wrong");
    status_read_a: assert property (take && byteData[6:0] == 7'h40 |=> targetClass == TGT_STATUS && readStrobe)
        else $error("status read wrong");
    cmd_write_a: assert property (take && byteData[6:0] == 7'h00 |=> targetClass == TGT_COMMAND && phaseDone)
        else $error("command write wrong");
    ident_map_a: assert property (take && byteData[5:0] == 6'h07 |=> targetClass == TGT_IDENT)
        else $error("ident map wrong");
    channel_map_a: assert property (take && byteData[5:4] == 2'h1 |=> targetUnit == $past(byteData[3:0]))
        else $error("channel unit wrong");
    gain_map_a: assert property (take && byteData[5:3] == 3'h7 |=> targetClass == TGT_GAIN && phaseBytes == 2'h3)
        else $error("gain map wrong");
    reserved_a: assert property (take && byteData[5:3] == 3'h1 |=> targetClass == TGT_NONE ##1 !writeStrobe)
        else $error("reserved access acted");
    write_end_a: assert property (writeStrobe |-> phaseDone && !phaseActive)
        else $error("write end wrong");
endmodule : command_byte_register_decoder_checker
bind command_byte_register_decoder command_byte_register_decoder_checker chk (.mclk(mclk), .rst_n(rst_n),
    .byteValid(byteValid), .byteData(byteData), .frameAbort(frameAbort), .commandByte(commandByte),
    .targetClass(targetClass), .targetUnit(targetUnit), .readNotWrite(readNotWrite), .phaseActive(phaseActive),
    .phaseBytes(phaseBytes), .readStrobe(readStrobe), .writeStrobe(writeStrobe), .phaseDone(phaseDone),
    .commandRejected(commandRejected));
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       mclk,
    output var logic        byteValid,
    output var logic [7:0]  byteData,
    output var logic        frameAbort
);
    initial
    begin
        byteValid = 1'b0;
        byteData = 8'h00;
        frameAbort = 1'b0;
    end
    // byte held until the edge that takes it; first byte of a frame is the command
    task automatic send(input logic [7:0] b);
        @(posedge mclk);
        #1;
        byteValid = 1'b1;
        byteData = b;
    endtask : send
    // released line shows no stale byte
    task automatic idle();
        @(posedge mclk);
        #1;
        byteValid = 1'b0;
        frameAbort = 1'b0;
        byteData = ~byteData;
    endtask : idle
    task automatic abort();
        @(posedge mclk);
        #1;
        byteValid = 1'b0;
        frameAbort = 1'b1;
        byteData = ~byteData;
    endtask : abort
endmodule : host_model
`default_nettype wire

// ==== command_byte_register_decoder_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module command_byte_register_decoder_test;
    import cmd_decoder_pkg::*;
    logic mclk, rst_n, byteValid, frameAbort;
    logic [7:0] byteData, commandByte;
    target_t targetClass;
    logic [3:0] targetUnit;
    logic [1:0] phaseBytes;
    logic [23:0] writeData;
    logic readNotWrite, phaseActive, readStrobe, writeStrobe, phaseDone, commandRejected;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    host_model host (.mclk(mclk), .byteValid(byteValid), .byteData(byteData), .frameAbort(frameAbort));
    command_byte_register_decoder DUT (.mclk(mclk), .rst_n(rst_n), .byteValid(byteValid), .byteData(byteData),
        .frameAbort(frameAbort), .commandByte(commandByte), .targetClass(targetClass), .targetUnit(targetUnit),
        .readNotWrite(readNotWrite), .phaseActive(phaseActive), .phaseBytes(phaseBytes), .readStrobe(readStrobe),
        .writeStrobe(writeStrobe), .writeData(writeData), .phaseDone(phaseDone), .commandRejected(commandRejected));
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // whole run needs about 650 cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            final_report();
        end
    end
    task automatic check(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    task automatic expect_of(input logic [7:0] c, output target_t k, output logic [3:0] u, output logic [1:0] n);
        casez (c[5:0])
            6'h00: k = c[6] ? TGT_STATUS : TGT_COMMAND;
            6'h01: k = TGT_CONV_MODE;
            6'h02: k = TGT_IFACE_MODE;
            6'h03: k = TGT_CHECKSUM;
            6'h04: k = TGT_RESULT;
            6'h06: k = TGT_GPIO_CFG;
            6'h07: k = TGT_IDENT;
            6'b01????: k = TGT_CHANNEL;
            6'b100???: k = TGT_SETUP;
            6'b101???: k = TGT_FILTER;
            6'b110???: k = TGT_OFFSET;
            6'b111???: k = TGT_GAIN;
            default: k = TGT_NONE;
        endcase
        u = c[5:4] == 2'h1 ? c[3:0] : (c[5] ? {1'b0, c[2:0]} : 4'h0);
        case (k)
            TGT_STATUS: n = 2'h1;
            TGT_CHECKSUM, TGT_RESULT, TGT_OFFSET, TGT_GAIN: n = 2'h3;
            TGT_NONE, TGT_COMMAND: n = 2'h0;
            default: n = 2'h2;
        endcase
    endtask : expect_of
    // every command code with a legal start bit, data bytes with bit 7 set
    task automatic t_sweep();
        logic [7:0] c;
        target_t k;
        logic [3:0] u;
        logic [1:0] n;
        logic [23:0] w;
        for (int i = 0; i < 128; i++)
        begin
            c = i[7:0];
            expect_of(c, k, u, n);
            host.send(c);
            host.idle();
            check(targetClass === k && targetUnit === u && commandByte === c && phaseBytes === n, "decode");
            check(readNotWrite === c[6] && readStrobe === (c[6] && n != 2'h0), "direction");
            check(phaseDone === (n == 2'h0) && phaseActive === (n != 2'h0), "phase start");
            if (n != 2'h0)
            begin
                w = 24'h000000;
                for (int j = 0; j < n; j++)
                begin
                    host.send(8'ha5 ^ c ^ j[7:0]);
                    w = {w[15:0], 8'ha5 ^ c ^ j[7:0]};
                end
                host.idle();
                check(writeStrobe === !c[6] && phaseDone === 1'b1 && !phaseActive && !commandRejected, "end");
                if (!c[6])
                    check(writeData === w, "write data");
            end
        end
    endtask : t_sweep
    task automatic t_reject();
        host.send(8'hc4);
        host.idle();
        check(commandRejected === 1'b1 && phaseActive === 1'b0 && commandByte === 8'h7f, "reject");
    endtask : t_reject
    task automatic t_abort();
        host.send(8'h31);
        host.send(8'h11);
        host.abort();
        host.idle();
        check(writeStrobe === 1'b0 && phaseDone === 1'b0 && phaseActive === 1'b0, "abort");
        host.send(8'h44);
        host.idle();
        check(targetClass === TGT_RESULT && phaseActive === 1'b1, "after abort");
    endtask : t_abort
    // reset in the middle of a data phase, then a back-to-back write
    task automatic t_midreset();
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        check(phaseActive === 1'b0 && commandByte === 8'h00 && targetClass === TGT_NONE && !readNotWrite, "mid reset");
        host.send(8'h01);
        host.send(8'h12);
        host.send(8'h34);
        host.idle();
        check(writeStrobe === 1'b1 && writeData === 24'h001234 && targetClass === TGT_CONV_MODE, "after reset");
        check(phaseDone === 1'b1 && phaseActive === 1'b0, "after reset end");
    endtask : t_midreset
    initial
    begin
        rst_n = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        check(commandByte === 8'h00 && targetClass === TGT_NONE && phaseActive === 1'b0, "reset");
        t_sweep();
        t_reject();
        t_abort();
        t_midreset();
        final_report();
    end
endmodule : command_byte_register_decoder_test
`default_nettype wire
